// ### tb.sv
`timescale 1ns/10ps

module tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic pix_valid = 1'b0;
  vec_pkg::vec_pix_t pix_in = '0;
  logic input_format_422 = 1'b0;
  logic [1:0] output_standard_field = 2'h0;
  logic sharpness_filter_enable = 1'b0;
  logic clk_en = 1'b1;
  logic [15:0] rd16;
  logic scl, sda_pull, sda_out, sda_oe, out_valid, ok;
  logic conv_a_enable, conv_b_enable, conv_c_enable, interp_enable;
  logic timing_counter_clear, rgb_input_select, sync_on_color_active;
  logic adaptive_active, adaptive_mode_b;
  logic signed [3:0] gain_a_field, gain_b_field;
  vec_pkg::vec_dac_t dac_out;
  vec_pkg::vec_pix_t pattern_color;
  logic [19:0] copy_protect_word;
  wire logic sda = ~(sda_pull | sda_oe);
  int errors = 0;
  int checks = 0;
  int pulses = 0;
  // Row: mode5 value, luma in, luma out
  logic [23:0] rows [13] = '{24'h001818, 24'h201820, 24'h202838, 24'h204050, 24'h20E8F0,
    24'h200808, 24'h20F8F8, 24'h201010, 24'h30142C, 24'h30C89E, 24'h30E5F5, 24'h30F0F0,
    24'h106464};
  logic [7:0] m3 [5] = '{8'h78, 8'h38, 8'h48, 8'h08, 8'h00};
  logic [2:0] stds [4] = '{3'b100, 3'b001, 3'b110, 3'b011};
  logic [3:0] adp [3] = '{4'b0000, 4'b1101, 4'b1011};
  logic [7:0] regs [8] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h13, 8'h21, 8'h0A};

  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (timing_counter_clear === 1'b1) pulses++;

  vec_encoder_ctrl u_dut (.core_clk, .reset, .clk_en, .scl, .sda_in(sda), .sda_out,
    .sda_oe, .pix_valid, .pix_in, .input_format_422, .output_standard_field,
    .sharpness_filter_enable, .out_valid, .dac_out, .conv_a_enable, .conv_b_enable,
    .conv_c_enable, .interp_enable, .timing_counter_clear, .rgb_input_select,
    .sync_on_color_active, .adaptive_active, .adaptive_mode_b, .gain_a_field,
    .gain_b_field, .pattern_color, .copy_protect_word);
  vec_host u_host (.core_clk, .sda, .scl, .sda_pull);

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr1(input logic [7:0] a, input logic [7:0] d);
    u_host.wr(vec_pkg::DEVICE_ADDRESS, a, '{d}, ok);
    chk(ok, 1'b1);
  endtask : wr1

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [15:0] d;
    u_host.rd(a, d, 1'b0);
    chk(d[15:8], exp);
  endtask : rdchk

  // Outputs read at the later edge see the value launched by the earlier one
  task automatic px(input logic [7:0] y, input logic is422, input logic [23:0] exp);
    pix_in <= '{y: y, cr: 8'h5A, cb: 8'hA5};
    input_format_422 <= is422;
    pix_valid <= 1'b1;
    @(posedge core_clk);
    pix_valid <= 1'b0;
    @(posedge core_clk);
    chk(dac_out, exp);
  endtask : px

  task automatic results;
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////
  // Roughly 80k cycles, well beyond the expected run
  initial begin
    #2000000;
    errors++;
    results();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    u_host.wr(vec_pkg::DEVICE_ADDRESS, 8'h14, '{8'h30, 8'h50, 8'h70, 8'h90, 8'hB0, 8'hD0,
      8'hF0, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'hF8}, ok);
    chk(ok, 1'b1);
    foreach (rows[i]) begin
      wr1(8'h05, rows[i][23:16]);
      px(rows[i][15:8], 1'b0, {rows[i][7:0], 8'h5A, 8'hA5});
    end
    // Setup value goes in before the interpolation bit is toggled
    wr1(8'h09, 8'h3E);
    foreach (m3[i]) begin
      wr1(8'h03, m3[i]);
      chk({interp_enable, conv_c_enable, conv_b_enable, conv_a_enable}, m3[i][6:3]);
    end
    wr1(8'h04, 8'h01);
    chk(24'(pulses), 24'h0);
    wr1(8'h04, 8'h00);
    chk(24'(pulses), 24'h1);
    u_host.wr(vec_pkg::DEVICE_ADDRESS, 8'h06, '{8'hEB, 8'h80, 8'h10}, ok);
    chk(pattern_color, 24'hEB8010);
    u_host.wr(vec_pkg::DEVICE_ADDRESS, 8'h10, '{8'h8F, 8'hA5, 8'h3C, 8'hF7}, ok);
    chk({gain_b_field, gain_a_field}, 8'h8F);
    chk(gain_a_field < 0 && gain_b_field == -4'sd8, 1'b1);
    chk(copy_protect_word, 20'h73CA5);
    wr1(8'h05, 8'hFF);
    rdchk(8'h05, 8'hFE);
    wr1(8'h05, 8'h04);
    foreach (stds[i]) begin
      output_standard_field <= stds[i][1:0];
      repeat (3) @(posedge core_clk);
      chk(sync_on_color_active, stds[i][2]);
    end
    output_standard_field <= 2'h0;
    wr1(8'h05, 8'h06);
    chk({rgb_input_select, sync_on_color_active}, 2'b10);
    wr1(8'h05, 8'hC0);
    foreach (adp[i]) begin
      sharpness_filter_enable <= adp[i][0];
      if (adp[i][1]) wr1(8'h05, 8'h80);
      repeat (3) @(posedge core_clk);
      chk({adaptive_active, adaptive_mode_b}, adp[i][3:2]);
    end
    wr1(8'h05, 8'h08);
    px(8'h08, 1'b0, 24'h08A55A);
    px(8'h08, 1'b1, 24'h0800A5);
    wr1(8'h05, 8'h00);
    px(8'h08, 1'b1, 24'h0800A5);
    // A low clock enable must hold the converter word
    clk_en <= 1'b0;
    px(8'h30, 1'b0, 24'h0800A5);
    clk_en <= 1'b1;
    // A foreign device address must be ignored
    u_host.wr(vec_pkg::DEVICE_ADDRESS ^ 7'h01, 8'h06, '{8'h00}, ok);
    chk(ok, 1'b0);
    rdchk(8'h06, 8'hEB);
    u_host.rd(8'h06, rd16, 1'b1);
    chk(rd16, 16'hEB80);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk(pattern_color, 24'h000000);
    chk({conv_c_enable, conv_b_enable, conv_a_enable, sda_oe, sda_out}, 5'h00);
    foreach (regs[i]) rdchk(regs[i], 8'h00);
    results();
  end
endmodule : tb

bind vec_encoder_ctrl vec_props u_props (.core_clk, .reset, .clk_en, .pix_valid, .pix_in,
  .input_format_422, .output_standard_field, .sharpness_filter_enable, .out_valid,
  .dac_out, .timing_counter_clear, .rgb_input_select, .sync_on_color_active,
  .adaptive_active, .adaptive_mode_b);

// ### vec_encoder_ctrl.sv
`timescale 1ns/10ps

// Function
// - Converter enable bits power each converter
// - Interpolation bit selects 54 MHz converter feed
// - Timing bit high-then-low clears timing counters
// - Revision bit is read-only
// - RGB select takes unsigned RGB input
// - Colour sync only for allowed standards, not RGB
// - Swap bit exchanges second and third converter in 4:4:4 mode only
// - 4:2:2 mode drives multiplexed pins to third converter
// - Curve select picks first or second curve
// - Gamma enable applies curve, else bypass
// - Adaptive mode needs both filter enables
// - Adaptive filtering needs sharpness enable too
// - Three test pattern colour registers
// - Copy-protect word split over three registers
// - Gain nibbles drive filters A and B
// - Fourteen gamma point registers, seven per curve
// - Gamma acts on luma only
// - Programmed points every 32, linear between
// - Points 0, 16, 240, 255 fixed
module vec_encoder_ctrl #(
  parameter logic REVISION_BIT = 1'b0
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic pix_valid,
  input wire vec_pkg::vec_pix_t pix_in,
  input wire logic input_format_422,
  input wire logic [1:0] output_standard_field,
  input wire logic sharpness_filter_enable,
  output logic out_valid,
  output vec_pkg::vec_dac_t dac_out,
  output logic conv_a_enable,
  output logic conv_b_enable,
  output logic conv_c_enable,
  output logic interp_enable,
  output logic timing_counter_clear,
  output logic rgb_input_select,
  output logic sync_on_color_active,
  output logic adaptive_active,
  output logic adaptive_mode_b,
  output logic signed [3:0] gain_a_field,
  output logic signed [3:0] gain_b_field,
  output vec_pkg::vec_pix_t pattern_color,
  output logic [19:0] copy_protect_word
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = (addr >= vec_pkg::ADDR_DAC_AND_INTERP_CONTROL &&
                  addr <= vec_pkg::ADDR_PLL_SETUP_VALUE) ||
                 (addr >= vec_pkg::ADDR_SHARPNESS_GAIN &&
                  addr <= vec_pkg::ADDR_GAMMA_POINT_LAST);
  endfunction : reg_mapped

  // Piecewise-linear curve through 16, seven programmed points, 240
  function automatic logic [7:0] gamma_map(input logic [7:0] x, input logic [55:0] pts);
    logic [7:0] ya;
    logic [7:0] yb;
    logic [4:0] off;
    logic [2:0] idx;
    logic edge_seg;
    logic signed [15:0] diff;
    logic signed [15:0] prod;
    logic signed [15:0] sum;
    ya = x;
    yb = x;
    off = 5'h00;
    idx = x[vec_pkg::SEG_INDEX_LSB +: 3];
    edge_seg = 1'b1;
    if (x < vec_pkg::FIRST_POINT) begin
      ya = vec_pkg::KNOT_LOW;
      yb = pts[7:0];
      off = 5'(x - vec_pkg::KNOT_LOW);
    end else if (x >= vec_pkg::LAST_POINT) begin
      ya = pts[55:48];
      yb = vec_pkg::KNOT_HIGH;
      off = 5'(x - vec_pkg::LAST_POINT);
    end else begin
      ya = pts[(3'(idx - 3'h1)) * 8 +: 8];
      yb = pts[idx * 8 +: 8];
      off = x[4:0];
      edge_seg = 1'b0;
    end
    diff = 16'(signed'({8'h00, yb})) - 16'(signed'({8'h00, ya}));
    prod = 16'(diff * signed'({11'h000, off}));
    if (edge_seg) begin
      sum = 16'(signed'({8'h00, ya})) + (prod >>> vec_pkg::SHIFT_EDGE);
    end else begin
      sum = 16'(signed'({8'h00, ya})) + (prod >>> vec_pkg::SHIFT_MID);
    end
    if (x < vec_pkg::KNOT_LOW || x > vec_pkg::KNOT_HIGH) begin
      gamma_map = x;
    end else begin
      gamma_map = sum[7:0];
    end
  endfunction : gamma_map

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire slave

  logic [7:0] regs [0:vec_pkg::REG_COUNT-1];
  vec_pkg::vec_state_t state;
  logic scl_q;
  logic sda_q;
  logic scl_prev;
  logic sda_prev;
  logic [7:0] shifter;
  logic [2:0] bit_cnt;
  logic byte_ready;
  logic read_mode;
  logic [7:0] sub_addr;
  logic wr_strobe;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic bus_start;
  logic bus_stop;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] rd_byte;

  assign bus_start = scl_q && scl_prev && sda_prev && !sda_q;
  assign bus_stop = scl_q && scl_prev && !sda_prev && sda_q;
  assign scl_rise = scl_q && !scl_prev;
  assign scl_fall = !scl_q && scl_prev;

  always_comb begin
    rd_byte = 8'h00;
    if (reg_mapped(sub_addr)) begin
      rd_byte = regs[sub_addr[5:0]];
    end
    if (sub_addr == vec_pkg::ADDR_FORMAT_AND_GAMMA_CONTROL) begin
      rd_byte[vec_pkg::BIT_REVISION] = REVISION_BIT;
    end
  end

  // Pins arrive synchronous; one stage only to find edges
  always_ff @(posedge core_clk) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else if (clk_en) begin
      scl_q <= scl;
      sda_q <= sda_in;
      scl_prev <= scl_q;
      sda_prev <= sda_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= vec_pkg::VEC_ST_IDLE;
      shifter <= 8'h00;
      bit_cnt <= 3'h0;
      byte_ready <= 1'b0;
      read_mode <= 1'b0;
      sub_addr <= 8'h00;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      wr_strobe <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else if (clk_en) begin
      wr_strobe <= 1'b0;
      if (bus_start) begin
        state <= vec_pkg::VEC_ST_DEVADDR;
        bit_cnt <= 3'h0;
        byte_ready <= 1'b0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state <= vec_pkg::VEC_ST_IDLE;
        sda_oe <= 1'b0;
      end else if (scl_rise) begin
        unique case (state)
          vec_pkg::VEC_ST_DEVADDR, vec_pkg::VEC_ST_SUBADDR, vec_pkg::VEC_ST_WDATA: begin
            shifter <= {shifter[6:0], sda_q};
            bit_cnt <= 3'(bit_cnt + 3'h1);
            byte_ready <= (bit_cnt == vec_pkg::LAST_BIT);
          end
          vec_pkg::VEC_ST_RACK: begin
            // A released line means the master is done reading
            if (sda_q) begin
              state <= vec_pkg::VEC_ST_IDLE;
            end else begin
              sub_addr <= 8'(sub_addr + 8'h01);
              state <= vec_pkg::VEC_ST_RNEXT;
            end
          end
          vec_pkg::VEC_ST_IDLE, vec_pkg::VEC_ST_ACK_DEV, vec_pkg::VEC_ST_ACK_SUB,
          vec_pkg::VEC_ST_ACK_WDATA, vec_pkg::VEC_ST_RDATA, vec_pkg::VEC_ST_RNEXT: begin
          end
        endcase
      end else if (scl_fall) begin
        if (byte_ready) begin
          byte_ready <= 1'b0;
          bit_cnt <= 3'h0;
          unique case (state)
            vec_pkg::VEC_ST_DEVADDR: begin
              if (shifter[7:1] == vec_pkg::DEVICE_ADDRESS) begin
                read_mode <= shifter[0];
                sda_oe <= 1'b1;
                state <= vec_pkg::VEC_ST_ACK_DEV;
              end else begin
                state <= vec_pkg::VEC_ST_IDLE;
              end
            end
            vec_pkg::VEC_ST_SUBADDR: begin
              sub_addr <= shifter;
              sda_oe <= 1'b1;
              state <= vec_pkg::VEC_ST_ACK_SUB;
            end
            default: begin
              wr_strobe <= 1'b1;
              wr_addr <= sub_addr;
              wr_data <= shifter;
              sda_oe <= 1'b1;
              state <= vec_pkg::VEC_ST_ACK_WDATA;
            end
          endcase
        end else begin
          unique case (state)
            vec_pkg::VEC_ST_ACK_DEV, vec_pkg::VEC_ST_RNEXT: begin
              if (read_mode) begin
                shifter <= rd_byte;
                sda_oe <= !rd_byte[7];
                bit_cnt <= 3'h0;
                state <= vec_pkg::VEC_ST_RDATA;
              end else begin
                sda_oe <= 1'b0;
                state <= vec_pkg::VEC_ST_SUBADDR;
              end
            end
            vec_pkg::VEC_ST_ACK_SUB: begin
              sda_oe <= 1'b0;
              state <= vec_pkg::VEC_ST_WDATA;
            end
            vec_pkg::VEC_ST_ACK_WDATA: begin
              // Auto-increment lets one frame load the whole curve table
              sda_oe <= 1'b0;
              sub_addr <= 8'(sub_addr + 8'h01);
              state <= vec_pkg::VEC_ST_WDATA;
            end
            vec_pkg::VEC_ST_RDATA: begin
              if (bit_cnt == vec_pkg::LAST_BIT) begin
                sda_oe <= 1'b0;
                state <= vec_pkg::VEC_ST_RACK;
              end else begin
                bit_cnt <= 3'(bit_cnt + 3'h1);
                sda_oe <= !shifter[6];
                shifter <= {shifter[6:0], 1'b0};
              end
            end
            vec_pkg::VEC_ST_IDLE, vec_pkg::VEC_ST_DEVADDR, vec_pkg::VEC_ST_SUBADDR,
            vec_pkg::VEC_ST_WDATA, vec_pkg::VEC_ST_RACK: begin
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < vec_pkg::REG_COUNT; i++) begin
        regs[i] <= vec_pkg::REG_RESET;
      end
    end else if (clk_en) begin
      // The setup register at 09 is held as written; host orders it first
      // Reserved top bit of mode 3 is stored as written
      if (wr_strobe && reg_mapped(wr_addr)) begin
        regs[wr_addr[5:0]] <= wr_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs

  logic [7:0] mode3;
  logic [7:0] mode5;
  logic timing_bit_prev;

  assign mode3 = regs[vec_pkg::ADDR_DAC_AND_INTERP_CONTROL[5:0]];
  assign mode5 = regs[vec_pkg::ADDR_FORMAT_AND_GAMMA_CONTROL[5:0]];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      conv_a_enable <= 1'b0;
      conv_b_enable <= 1'b0;
      conv_c_enable <= 1'b0;
      interp_enable <= 1'b0;
      rgb_input_select <= 1'b0;
      sync_on_color_active <= 1'b0;
      adaptive_active <= 1'b0;
      adaptive_mode_b <= 1'b0;
      gain_a_field <= 4'sh0;
      gain_b_field <= 4'sh0;
      pattern_color <= '0;
      copy_protect_word <= 20'h00000;
    end else if (clk_en) begin
      conv_a_enable <= mode3[vec_pkg::BIT_CONV_A_ENABLE];
      conv_b_enable <= mode3[vec_pkg::BIT_CONV_B_ENABLE];
      conv_c_enable <= mode3[vec_pkg::BIT_CONV_C_ENABLE];
      interp_enable <= mode3[vec_pkg::BIT_INTERP_ENABLE];
      rgb_input_select <= mode5[vec_pkg::BIT_RGB_INPUT_SELECT];
      sync_on_color_active <= mode5[vec_pkg::BIT_SYNC_ON_COLOR_DIFF] &&
        (output_standard_field == vec_pkg::STD_SYNC_OK_0 ||
         output_standard_field == vec_pkg::STD_SYNC_OK_1) &&
        !mode5[vec_pkg::BIT_RGB_INPUT_SELECT];
      adaptive_active <= mode5[vec_pkg::BIT_ADAPTIVE_FILTER_ENABLE] &&
        sharpness_filter_enable;
      adaptive_mode_b <= mode5[vec_pkg::BIT_ADAPTIVE_MODE_SELECT] &&
        mode5[vec_pkg::BIT_ADAPTIVE_FILTER_ENABLE] && sharpness_filter_enable;
      gain_a_field <= signed'(regs[vec_pkg::ADDR_SHARPNESS_GAIN[5:0]]
        [vec_pkg::GAIN_A_LSB +: vec_pkg::GAIN_WIDTH]);
      gain_b_field <= signed'(regs[vec_pkg::ADDR_SHARPNESS_GAIN[5:0]]
        [vec_pkg::GAIN_B_LSB +: vec_pkg::GAIN_WIDTH]);
      pattern_color.y <= regs[vec_pkg::ADDR_PATTERN_LUMA_COLOR[5:0]];
      pattern_color.cr <= regs[vec_pkg::ADDR_PATTERN_RED_DIFF_COLOR[5:0]];
      pattern_color.cb <= regs[vec_pkg::ADDR_PATTERN_BLUE_DIFF_COLOR[5:0]];
      copy_protect_word <= {
        regs[vec_pkg::ADDR_COPY_PROTECT_DATA_HIGH[5:0]][vec_pkg::CP_HIGH_WIDTH-1:0],
        regs[vec_pkg::ADDR_COPY_PROTECT_DATA_MID[5:0]],
        regs[vec_pkg::ADDR_COPY_PROTECT_DATA_LOW[5:0]]};
    end
  end

  // A clear needs the bit raised and dropped again; a held high does nothing
  always_ff @(posedge core_clk) begin
    if (reset) begin
      timing_bit_prev <= 1'b0;
      timing_counter_clear <= 1'b0;
    end else if (clk_en) begin
      timing_bit_prev <= regs[vec_pkg::ADDR_TIMING_RESET_CONTROL[5:0]]
        [vec_pkg::BIT_TIMING_COUNTER_RESET];
      timing_counter_clear <= timing_bit_prev &&
        !regs[vec_pkg::ADDR_TIMING_RESET_CONTROL[5:0]][vec_pkg::BIT_TIMING_COUNTER_RESET];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Luma gamma and converter routing

  logic [55:0] curve_pts;

  always_comb begin
    curve_pts = 56'h0;
    for (int i = 0; i < vec_pkg::GAMMA_POINTS_PER_CURVE; i++) begin
      if (mode5[vec_pkg::BIT_GAMMA_CURVE_SELECT]) begin
        curve_pts[i*8 +: 8] = regs[6'(vec_pkg::ADDR_GAMMA_POINT_FIRST[5:0] +
          vec_pkg::GAMMA_POINTS_PER_CURVE + i)];
      end else begin
        curve_pts[i*8 +: 8] = regs[6'(vec_pkg::ADDR_GAMMA_POINT_FIRST[5:0] + i)];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      out_valid <= 1'b0;
      dac_out <= '0;
    end else if (clk_en) begin
      out_valid <= pix_valid;
      if (pix_valid) begin
        if (mode5[vec_pkg::BIT_GAMMA_ENABLE]) begin
          dac_out.dac_a <= gamma_map(pix_in.y, curve_pts);
        end else begin
          dac_out.dac_a <= pix_in.y;
        end
        // Colour values pass untouched; 4:2:2 drops cr and zeroes the second converter
        if (input_format_422) begin
          dac_out.dac_b <= 8'h00;
          dac_out.dac_c <= pix_in.cb;
        end else if (mode5[vec_pkg::BIT_COLOR_OUTPUT_SWAP]) begin
          dac_out.dac_b <= pix_in.cb;
          dac_out.dac_c <= pix_in.cr;
        end else begin
          dac_out.dac_b <= pix_in.cr;
          dac_out.dac_c <= pix_in.cb;
        end
      end
    end
  end

endmodule : vec_encoder_ctrl

// ### vec_host.sv
`timescale 1ns/10ps

module vec_host (
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  // Released bus: the pull-up holds the data line high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // Six cycles a phase leaves margin over the four the port needs
  task automatic put_bit(input logic b);
    scl <= 1'b0;
    tick(3);
    sda_pull <= ~b;
    tick(3);
    scl <= 1'b1;
    tick(6);
  endtask : put_bit

  // Release one cycle after the fall so it never looks like a stop
  task automatic get_bit(output logic b);
    scl <= 1'b0;
    tick(1);
    sda_pull <= 1'b0;
    tick(5);
    scl <= 1'b1;
    tick(3);
    b = sda;
    tick(3);
  endtask : get_bit

  // Start is frame(0,1), stop is frame(1,0)
  task automatic frame(input logic first, input logic second);
    scl <= 1'b0;
    tick(3);
    sda_pull <= first;
    tick(3);
    scl <= 1'b1;
    tick(6);
    sda_pull <= second;
    tick(6);
  endtask : frame

  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = ~b;
  endtask : byte_out

  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d[$],
                    output logic ok);
    logic k;
    frame(1'b0, 1'b1);
    byte_out({dev, 1'b0}, ok);
    byte_out(a, k);
    ok = ok & k;
    foreach (d[i]) begin
      byte_out(d[i], k);
      ok = ok & k;
    end
    frame(1'b1, 1'b0);
  endtask : wr

  // With two set the master acks the first byte and reads the next address
  task automatic rd(input logic [7:0] a, output logic [15:0] d, input logic two);
    logic k;
    frame(1'b0, 1'b1);
    byte_out({vec_pkg::DEVICE_ADDRESS, 1'b0}, k);
    byte_out(a, k);
    frame(1'b0, 1'b1);
    byte_out({vec_pkg::DEVICE_ADDRESS, 1'b1}, k);
    d = 16'h0000;
    for (int i = 15; i >= 8; i--) get_bit(d[i]);
    if (two) begin
      put_bit(1'b0);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
    end
    put_bit(1'b1);
    frame(1'b1, 1'b0);
  endtask : rd
endmodule : vec_host

// ### vec_pkg.sv
package vec_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map (sub-addresses on the two-wire port)
  localparam logic [7:0] ADDR_DAC_AND_INTERP_CONTROL = 8'h03;
  localparam logic [7:0] ADDR_TIMING_RESET_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_FORMAT_AND_GAMMA_CONTROL = 8'h05;
  localparam logic [7:0] ADDR_PATTERN_LUMA_COLOR = 8'h06;
  localparam logic [7:0] ADDR_PATTERN_RED_DIFF_COLOR = 8'h07;
  localparam logic [7:0] ADDR_PATTERN_BLUE_DIFF_COLOR = 8'h08;
  localparam logic [7:0] ADDR_PLL_SETUP_VALUE = 8'h09;
  localparam logic [7:0] ADDR_SHARPNESS_GAIN = 8'h10;
  localparam logic [7:0] ADDR_COPY_PROTECT_DATA_LOW = 8'h11;
  localparam logic [7:0] ADDR_COPY_PROTECT_DATA_MID = 8'h12;
  localparam logic [7:0] ADDR_COPY_PROTECT_DATA_HIGH = 8'h13;
  localparam logic [7:0] ADDR_GAMMA_POINT_FIRST = 8'h14;
  localparam logic [7:0] ADDR_GAMMA_POINT_LAST = 8'h21;
  localparam int REG_COUNT = 34;
  localparam int GAMMA_POINTS_PER_CURVE = 7;
  localparam logic [7:0] REG_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int BIT_CONV_A_ENABLE = 3;
  localparam int BIT_CONV_B_ENABLE = 4;
  localparam int BIT_CONV_C_ENABLE = 5;
  localparam int BIT_INTERP_ENABLE = 6;
  localparam int BIT_TIMING_COUNTER_RESET = 0;
  localparam int BIT_REVISION = 0;
  localparam int BIT_RGB_INPUT_SELECT = 1;
  localparam int BIT_SYNC_ON_COLOR_DIFF = 2;
  localparam int BIT_COLOR_OUTPUT_SWAP = 3;
  localparam int BIT_GAMMA_CURVE_SELECT = 4;
  localparam int BIT_GAMMA_ENABLE = 5;
  localparam int BIT_ADAPTIVE_MODE_SELECT = 6;
  localparam int BIT_ADAPTIVE_FILTER_ENABLE = 7;
  localparam int GAIN_A_LSB = 0;
  localparam int GAIN_B_LSB = 4;
  localparam int GAIN_WIDTH = 4;
  localparam int CP_HIGH_WIDTH = 4;
  localparam int CP_WORD_WIDTH = 20;
  localparam logic [1:0] STD_SYNC_OK_0 = 2'h0;
  localparam logic [1:0] STD_SYNC_OK_1 = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Gamma curve geometry
  localparam logic [7:0] KNOT_LOW = 8'h10;
  localparam logic [7:0] KNOT_HIGH = 8'hF0;
  localparam logic [7:0] FIRST_POINT = 8'h20;
  localparam logic [7:0] LAST_POINT = 8'hE0;
  localparam int SEG_INDEX_LSB = 5;
  localparam int SHIFT_EDGE = 4;
  localparam int SHIFT_MID = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire port
  localparam logic [6:0] DEVICE_ADDRESS = 7'h2A;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [3:0] {
    VEC_ST_IDLE = 4'h0,
    VEC_ST_DEVADDR = 4'h1,
    VEC_ST_ACK_DEV = 4'h2,
    VEC_ST_SUBADDR = 4'h3,
    VEC_ST_ACK_SUB = 4'h4,
    VEC_ST_WDATA = 4'h5,
    VEC_ST_ACK_WDATA = 4'h6,
    VEC_ST_RDATA = 4'h7,
    VEC_ST_RACK = 4'h8,
    VEC_ST_RNEXT = 4'h9
  } vec_state_t;

  typedef struct packed {
    logic [7:0] y;
    logic [7:0] cr;
    logic [7:0] cb;
  } vec_pix_t;

  typedef struct packed {
    logic [7:0] dac_a;
    logic [7:0] dac_b;
    logic [7:0] dac_c;
  } vec_dac_t;

endpackage : vec_pkg

// ### vec_props.sv
`timescale 1ns/10ps

module vec_props (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic pix_valid,
  input wire vec_pkg::vec_pix_t pix_in,
  input wire logic input_format_422,
  input wire logic [1:0] output_standard_field,
  input wire logic sharpness_filter_enable,
  input wire logic out_valid,
  input wire vec_pkg::vec_dac_t dac_out,
  input wire logic timing_counter_clear,
  input wire logic rgb_input_select,
  input wire logic sync_on_color_active,
  input wire logic adaptive_active,
  input wire logic adaptive_mode_b
);
  default clocking clk_def @(posedge core_clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  valid_delay_a: assert property (clk_en |=> out_valid == $past(pix_valid))
    else $error("pixel qualifier delay wrong");
  edge_pass_a: assert property (clk_en && pix_valid &&
    (pix_in.y < 8'h10 || pix_in.y > 8'hF0) |=> dac_out.dac_a == $past(pix_in.y))
    else $error("luma outside curve range altered");
  chroma_422_a: assert property (clk_en && pix_valid && input_format_422
    |=> dac_out.dac_b == 8'h00 && dac_out.dac_c == $past(pix_in.cb))
    else $error("multiplexed colour not on third converter");
  chroma_444_a: assert property (clk_en && pix_valid && !input_format_422
    |=> (dac_out.dac_b == $past(pix_in.cr) && dac_out.dac_c == $past(pix_in.cb))
    || (dac_out.dac_b == $past(pix_in.cb) && dac_out.dac_c == $past(pix_in.cr)))
    else $error("colour difference altered");
  // The stored RGB select bit gates colour sync off, so the two are never high together
  sync_gate_a: assert property (sync_on_color_active |->
    !rgb_input_select && !$past(output_standard_field[0]))
    else $error("colour sync in a barred mode");
  adapt_need_a: assert property (adaptive_active |-> $past(sharpness_filter_enable))
    else $error("adaptive filter without sharpness enable");
  mode_b_gate_a: assert property (adaptive_mode_b |-> adaptive_active)
    else $error("adaptive mode without adaptive filter");
  clear_pulse_a: assert property (timing_counter_clear |=> !timing_counter_clear)
    else $error("timing clear longer than one cycle");

  clear_c: cover property (timing_counter_clear);
  mode_b_c: cover property (adaptive_mode_b);
  sync_c: cover property (sync_on_color_active);
endmodule : vec_props
